// >>> design/cam_cfg.svh
// Purpose: Offsets, fields, reset values and timing counts for the
//          search-device host controller.
// Assumes: 50 MHz system clock.
// Notes:   Definitions only.
`ifndef CAM_CFG_SVH
`define CAM_CFG_SVH

// ==========================================================
// Software register offsets
`define CAM_OFF_CTRL 8'h00
`define CAM_OFF_CMD 8'h04
`define CAM_OFF_WDATA 8'h08
`define CAM_OFF_RDATA 8'h0C
`define CAM_OFF_STATUS 8'h10

// ==========================================================
// Control fields and reset value
`define CAM_CTRL_STRAP 0
`define CAM_CTRL_WID_LO 1
`define CAM_CTRL_WID_HI 2
`define CAM_CTRL_POS_POL 3
`define CAM_CTRL_RST 4'h0

// ==========================================================
// Command fields
`define CAM_CMD_OP_HI 2
`define CAM_CMD_SEL_LO 8
`define CAM_CMD_SEL_HI 15

// ==========================================================
// Key width codes
`define CAM_WID_8 2'h1
`define CAM_WID_16 2'h2

// ==========================================================
// Status fields
`define CAM_ST_BUSY 0
`define CAM_ST_FIRST 1
`define CAM_ST_SECOND 2
`define CAM_ST_MATCH 3

// ==========================================================
// Timing
`define CAM_CLK_NS 20
`define CAM_PULSE_NS 40
// Least time: round up
`define CAM_HRST_CYC ((`CAM_PULSE_NS + `CAM_CLK_NS - 1) / `CAM_CLK_NS)
// Strictly longer than the figure
`define CAM_SQCLR_CYC (`CAM_PULSE_NS / `CAM_CLK_NS + 1)
// Strobe active long enough to cover the three-stage input path
`define CAM_ACC_CYC 6

`endif

// >>> design/cam_pkg.sv
// Purpose: Types for the search-device host controller.
// Assumes: Nothing beyond the config header.
// Notes:   Types only; numbers live in cam_cfg.svh.
package cam_pkg;

    // ==========================================================
    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETUP = 2'b01,
        ST_ACTIVE = 2'b10,
        ST_RECOVER = 2'b11
    } cam_state_e;

    // ==========================================================
    // Operations started through the command register
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_HOST_WR = 3'b001,
        OP_HOST_RD = 3'b010,
        OP_KEY = 3'b011,
        OP_RESULT = 3'b100,
        OP_HARD_RST = 3'b101,
        OP_SEQ_CLR = 3'b110
    } cam_op_e;

endpackage

// >>> design/cam_sync3.sv
// Purpose: Three-stage input path for pins from outside the clock.
// Assumes: Single clock, asynchronous active-high reset.
// Notes:   Output moves only when stages two and three agree.
`timescale 1ns/1ps
module cam_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] syncOut
);

    logic [W-1:0] s1_q, s2_q, s3_q, out_q;
    logic [W-1:0] out_d;

    // ==========================================================
    // Accept a value only after it stood for two samples
    always_comb begin
        out_d = out_q;
        if (s2_q == s3_q) begin
            out_d = s3_q;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
            out_q <= INIT;
        end else begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end

    assign syncOut = out_q;

endmodule

// >>> design/cam_host_ctrl.sv
// Purpose: Host-side controller driving the pins of a three-port
//          search device: host word port, key port, result port.
// Assumes: Device has no clock; every pin edge is made here.
// Notes:   One operation at a time; commands while busy are dropped.
//
// Contract
// - Present eight-bit register select per access
// - Direction low writes, high reads
// - Hard reset low pulse, at least 40ns
// - Sequence clear held low over 40ns
// - Upstream match fed from higher device; the code always ties it high instead
// - Upstream match tied high when alone
`timescale 1ns/1ps
`include "cam_cfg.svh"
module cam_host_ctrl (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    output logic portSelN,
    output logic rwN,
    output logic [7:0] regSel,
    output logic [15:0] hostWordBusOut,
    output logic hostWordBusOe,
    input wire logic [15:0] hostWordBusIn,
    output logic hardResetN,
    output logic sequencePointerClearN,
    output logic [31:0] searchKeyBus,
    output logic keyStrobe,
    output logic resultRdN,
    output logic resultOeN,
    input wire logic [31:0] resultBus,
    input wire logic firstPortStatusN,
    input wire logic secondPortStatusN,
    input wire logic matchFlagOutN,
    output logic portCountStrap,
    output logic upstreamMatchInN
);

    // ==========================================================
    // State
    cam_pkg::cam_state_e state_q, state_d;
    cam_pkg::cam_op_e op_q, op_d;
    logic [3:0] cnt_q, cnt_d;
    logic [3:0] ctrl_q, ctrl_d;
    logic [31:0] wdata_q, wdata_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] rdOut_q, rdOut_d;
    logic portSel_q, portSel_d, rw_q, rw_d, oe_q, oe_d;
    logic [7:0] sel_q, sel_d;
    logic [15:0] word_q, word_d;
    logic hrst_q, hrst_d, sqclr_q, sqclr_d;
    logic [31:0] key_q, key_d;
    logic kstb_q, kstb_d, resRd_q, resRd_d, resOe_q, resOe_d;
    logic [3:0] lenLast;
    logic [31:0] keyMasked;
    logic [2:0] cmdOp;
    logic [15:0] hostWordSync;
    logic [31:0] resultSync;
    logic [2:0] statSync;

    // ==========================================================
    // Pin inputs through three stages
    cam_sync3 #(.W(16), .INIT(16'h0000)) uSyncWord (
        .clk_sys(clk_sys),
        .rst(rst),
        .pinIn(hostWordBusIn),
        .syncOut(hostWordSync)
    );

    cam_sync3 #(.W(32), .INIT(32'h0000_0000)) uSyncResult (
        .clk_sys(clk_sys),
        .rst(rst),
        .pinIn(resultBus),
        .syncOut(resultSync)
    );

    // Status pins idle high, so reset them high too
    cam_sync3 #(.W(3), .INIT(3'h7)) uSyncStat (
        .clk_sys(clk_sys),
        .rst(rst),
        .pinIn({matchFlagOutN, secondPortStatusN, firstPortStatusN}),
        .syncOut(statSync)
    );

    // ==========================================================
    // Key width mask and strobe length per operation
    always_comb begin
        keyMasked = wdata_q;
        if (ctrl_q[`CAM_CTRL_WID_HI:`CAM_CTRL_WID_LO] == `CAM_WID_8) begin
            keyMasked = {24'h00_0000, wdata_q[7:0]};
        end else if (ctrl_q[`CAM_CTRL_WID_HI:`CAM_CTRL_WID_LO]
                     == `CAM_WID_16) begin
            keyMasked = {16'h0000, wdata_q[15:0]};
        end
        if (op_q == cam_pkg::OP_HARD_RST) begin
            lenLast = 4'(`CAM_HRST_CYC - 1);
        end else if (op_q == cam_pkg::OP_SEQ_CLR) begin
            lenLast = 4'(`CAM_SQCLR_CYC - 1);
        end else begin
            lenLast = 4'(`CAM_ACC_CYC - 1);
        end
    end

    assign cmdOp = regWrData[`CAM_CMD_OP_HI:0];

    // ==========================================================
    // Register port and pin sequencer
    always_comb begin
        state_d = state_q;
        op_d = op_q;
        cnt_d = cnt_q;
        ctrl_d = ctrl_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        rdOut_d = 32'h0000_0000;
        portSel_d = portSel_q;
        rw_d = rw_q;
        oe_d = oe_q;
        sel_d = sel_q;
        word_d = word_q;
        hrst_d = hrst_q;
        sqclr_d = sqclr_q;
        key_d = key_q;
        kstb_d = kstb_q;
        resRd_d = resRd_q;
        resOe_d = resOe_q;
        // Address decode for software writes
        if (regWr) begin
            if (regAddr == `CAM_OFF_CTRL) begin
                ctrl_d = regWrData[3:0];
            end else if (regAddr == `CAM_OFF_WDATA && state_q
                         == cam_pkg::ST_IDLE) begin
                wdata_d = regWrData;
            end
        end
        // Reads answer one cycle later; unmapped reads give zero
        if (regRd) begin
            if (regAddr == `CAM_OFF_CTRL) begin
                rdOut_d = {28'h000_0000, ctrl_q};
            end else if (regAddr == `CAM_OFF_WDATA) begin
                rdOut_d = wdata_q;
            end else if (regAddr == `CAM_OFF_RDATA) begin
                rdOut_d = rdata_q;
            end else if (regAddr == `CAM_OFF_STATUS) begin
                // Meaning of the two status bits follows the strap
                rdOut_d = {28'h000_0000, ~statSync[2], ~statSync[1],
                           ~statSync[0], state_q != cam_pkg::ST_IDLE};
            end
        end
        case (state_q)
            cam_pkg::ST_IDLE: begin
                kstb_d = ~ctrl_q[`CAM_CTRL_POS_POL];
                if (regWr && regAddr == `CAM_OFF_CMD
                    && cmdOp != 3'h0 && cmdOp != 3'h7) begin
                    op_d = cam_pkg::cam_op_e'(cmdOp);
                    state_d = cam_pkg::ST_SETUP;
                    cnt_d = 4'h0;
                    sel_d = regWrData[`CAM_CMD_SEL_HI:`CAM_CMD_SEL_LO];
                    rw_d = (cmdOp != 3'(cam_pkg::OP_HOST_WR));
                    oe_d = (cmdOp == 3'(cam_pkg::OP_HOST_WR));
                    word_d = wdata_q[15:0];
                    key_d = keyMasked;
                end
            end
            cam_pkg::ST_SETUP: begin
                // Lines settled one cycle before the strobe edge
                state_d = cam_pkg::ST_ACTIVE;
                case (op_q)
                    cam_pkg::OP_HOST_WR, cam_pkg::OP_HOST_RD: begin
                        portSel_d = 1'b0;
                    end
                    cam_pkg::OP_KEY: begin
                        kstb_d = ctrl_q[`CAM_CTRL_POS_POL];
                    end
                    cam_pkg::OP_RESULT: begin
                        resRd_d = 1'b0;
                        resOe_d = 1'b0;
                    end
                    cam_pkg::OP_HARD_RST: begin
                        hrst_d = 1'b0;
                    end
                    cam_pkg::OP_SEQ_CLR: begin
                        sqclr_d = 1'b0;
                    end
                    default: begin
                        state_d = cam_pkg::ST_IDLE;
                    end
                endcase
            end
            cam_pkg::ST_ACTIVE: begin
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == lenLast) begin
                    if (op_q == cam_pkg::OP_HOST_RD) begin
                        rdata_d = {16'h0000, hostWordSync};
                    end else if (op_q == cam_pkg::OP_RESULT) begin
                        rdata_d = resultSync;
                    end
                    portSel_d = 1'b1;
                    kstb_d = ~ctrl_q[`CAM_CTRL_POS_POL];
                    resRd_d = 1'b1;
                    resOe_d = 1'b1;
                    hrst_d = 1'b1;
                    sqclr_d = 1'b1;
                    state_d = cam_pkg::ST_RECOVER;
                end
            end
            cam_pkg::ST_RECOVER: begin
                // Hold write data one cycle past the select rising
                oe_d = 1'b0;
                rw_d = 1'b1;
                state_d = cam_pkg::ST_IDLE;
            end
            default: begin
                state_d = cam_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= cam_pkg::ST_IDLE;
            op_q <= cam_pkg::OP_NONE;
            cnt_q <= 4'h0;
            ctrl_q <= `CAM_CTRL_RST;
            wdata_q <= 32'h0000_0000;
            rdata_q <= 32'h0000_0000;
            rdOut_q <= 32'h0000_0000;
            portSel_q <= 1'b1;
            rw_q <= 1'b1;
            oe_q <= 1'b0;
            sel_q <= 8'h00;
            word_q <= 16'h0000;
            hrst_q <= 1'b1;
            sqclr_q <= 1'b1;
            key_q <= 32'h0000_0000;
            kstb_q <= 1'b1;
            resRd_q <= 1'b1;
            resOe_q <= 1'b1;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            cnt_q <= cnt_d;
            ctrl_q <= ctrl_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            rdOut_q <= rdOut_d;
            portSel_q <= portSel_d;
            rw_q <= rw_d;
            oe_q <= oe_d;
            sel_q <= sel_d;
            word_q <= word_d;
            hrst_q <= hrst_d;
            sqclr_q <= sqclr_d;
            key_q <= key_d;
            kstb_q <= kstb_d;
            resRd_q <= resRd_d;
            resOe_q <= resOe_d;
        end
    end

    // ==========================================================
    // Pin drive from flip-flops, bar the tied-high upstream match
    assign regRdData = rdOut_q;
    assign portSelN = portSel_q;
    assign rwN = rw_q;
    assign regSel = sel_q;
    assign hostWordBusOut = word_q;
    assign hostWordBusOe = oe_q;
    assign hardResetN = hrst_q;
    assign sequencePointerClearN = sqclr_q;
    assign searchKeyBus = key_q;
    assign keyStrobe = kstb_q;
    assign resultRdN = resRd_q;
    assign resultOeN = resOe_q;
    assign portCountStrap = ctrl_q[`CAM_CTRL_STRAP];
    // Controller sees a lone device or the head of a chain
    assign upstreamMatchInN = 1'b1;

endmodule

// >>> testbench/cam_host_ctrl_chk.sv
// Purpose: Port-level timing checks on the search-device controller.
// Assumes: Single clock clk_sys, asynchronous active-high rst.
// Notes:   Pulse widths follow the controller's fixed cycle counts.
`timescale 1ns/1ps
module cam_host_ctrl_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic regRd,
    input wire logic [31:0] regRdData,
    input wire logic portSelN,
    input wire logic rwN,
    input wire logic [7:0] regSel,
    input wire logic [15:0] hostWordBusOut,
    input wire logic hostWordBusOe,
    input wire logic hardResetN,
    input wire logic sequencePointerClearN,
    input wire logic resultRdN,
    input wire logic resultOeN,
    input wire logic upstreamMatchInN
);
    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_drive_write_only: assert property (hostWordBusOe |-> !rwN)
        else $error("word bus driven outside a write");
    a_select_fall_stable: assert property ($fell(portSelN) |->
        $stable(rwN) && $stable(regSel) && $stable(hostWordBusOut))
        else $error("select fell while qualifiers moved");
    a_select_width: assert property ($fell(portSelN) |->
        !portSelN [*6] ##1 portSelN)
        else $error("select low width wrong");
    a_hard_reset_width: assert property ($fell(hardResetN) |->
        !hardResetN [*2] ##1 hardResetN)
        else $error("hard reset width wrong");
    a_seq_clear_width: assert property (
        $fell(sequencePointerClearN) |->
        !sequencePointerClearN [*3] ##1 sequencePointerClearN)
        else $error("sequence clear width wrong");
    a_result_read_span: assert property ($fell(resultRdN) |->
        (!resultRdN && !resultOeN) [*6] ##1 (resultRdN && resultOeN))
        else $error("result read span wrong");
    a_result_oe_in_read: assert property (!resultOeN |-> !resultRdN)
        else $error("result enable outside read");
    a_upstream_high: assert property (upstreamMatchInN)
        else $error("upstream match input not high");
    a_one_op_at_time: assert property (!portSelN |->
        resultRdN && hardResetN && sequencePointerClearN)
        else $error("two device operations overlap");
    a_rdata_idle_zero: assert property (!$past(regRd) |-> regRdData == 32'h0)
        else $error("read data outside answer cycle");
    // Main scenarios reached
    c_host_access: cover property ($fell(portSelN));
    c_result_read: cover property ($fell(resultRdN));
    c_hard_reset: cover property ($fell(hardResetN));
endmodule

bind cam_host_ctrl cam_host_ctrl_chk chk_u (
    .clk_sys(clk_sys), .rst(rst), .regRd(regRd), .regRdData(regRdData),
    .portSelN(portSelN), .rwN(rwN), .regSel(regSel),
    .hostWordBusOut(hostWordBusOut), .hostWordBusOe(hostWordBusOe),
    .hardResetN(hardResetN),
    .sequencePointerClearN(sequencePointerClearN),
    .resultRdN(resultRdN), .resultOeN(resultOeN),
    .upstreamMatchInN(upstreamMatchInN)
);

// >>> testbench/cam_dev_model.sv
// Purpose: Behavioural clockless model of the three-port search device.
// Assumes: Sixteen host registers, low select bits pick one.
// Notes:   Released buses show the inverted word, never a held value.
`timescale 1ns/1ps
module cam_dev_model #(
    parameter logic [31:0] HIT_KEY = 32'h0000CDEF,
    parameter logic [31:0] RES_BASE = 32'hC0DE0000
) (
    input wire logic portSelN,
    input wire logic rwN,
    input wire logic [7:0] regSel,
    input wire logic [15:0] hostWordBusOut,
    input wire logic hostWordBusOe,
    output logic [15:0] hostWordBusIn,
    input wire logic hardResetN,
    input wire logic sequencePointerClearN,
    input wire logic [31:0] searchKeyBus,
    input wire logic keyStrobe,
    input wire logic posPol,
    input wire logic resultRdN,
    input wire logic resultOeN,
    output logic [31:0] resultBus,
    input wire logic portCountStrap,
    input wire logic upstreamMatchInN,
    output logic firstPortStatusN,
    output logic secondPortStatusN,
    output logic matchFlagOutN
);
    // ==========================================================
    // Storage
    logic [15:0] mem [0:15];
    logic [31:0] keyQ = 32'h0;
    logic [31:0] resWord = RES_BASE;
    logic [15:0] rdWord;
    logic hitQ = 1'b0;
    logic [15:0] ptr = 16'h0;
    initial begin
        for (int i = 0; i < 16; i++) mem[i] = 16'h0;
    end
    // Latch on select fall; low direction writes
    always @(negedge portSelN) begin
        if (!rwN) mem[regSel[3:0]] = hostWordBusOut;
    end
    // Low pulse wipes registers, hit flag and pointer; key and result word kept
    always @(negedge hardResetN) begin
        for (int i = 0; i < 16; i++) mem[i] = 16'h0;
        hitQ = 1'b0;
        ptr = 16'h0;
    end
    // Pointer back to start
    always @(negedge sequencePointerClearN) ptr = 16'h0;
    // Key taken on the configured edge only
    always @(negedge keyStrobe) if (!posPol) keyQ = searchKeyBus;
    always @(posedge keyStrobe) if (posPol) keyQ = searchKeyBus;
    always @(keyQ) hitQ = (keyQ == HIT_KEY);
    // Each read starts on the read strobe fall
    always @(negedge resultRdN) begin
        resWord = RES_BASE | {16'h0, ptr};
        ptr = ptr + 16'h1;
    end
    // Bus turns only on read with select low
    assign rdWord = mem[regSel[3:0]];
    assign hostWordBusIn = hostWordBusOe ? hostWordBusOut :
        (!portSelN && rwN) ? rdWord : ~rdWord;
    // Result bus shows the inverted word when enable high
    assign resultBus = !resultOeN ? resWord : ~resWord;
    // Status roles by strap
    assign firstPortStatusN = !(!resultRdN || (!portCountStrap && !portSelN));
    assign secondPortStatusN = !((posPol ? keyStrobe : !keyStrobe) ||
        (!portCountStrap && !portSelN));
    // Own hit or upstream low pulls flag
    assign matchFlagOutN = !(hitQ || !upstreamMatchInN);
endmodule

// >>> testbench/cam_three_port_pin_interface_tb.sv
// Purpose: Register-level tests of the search-device controller.
// Assumes: Device model on the pins, 50 MHz clock.
// Notes:   Every operation is polled to idle through status.
`timescale 1ns/1ps
`include "cam_cfg.svh"
module cam_three_port_pin_interface_tb;
    logic clk_sys = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic posPol = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0, regRdData, searchKeyBus, resultBus;
    logic portSelN, rwN, hostWordBusOe, hardResetN, sequencePointerClearN;
    logic keyStrobe, resultRdN, resultOeN, portCountStrap, upstreamMatchInN;
    logic firstPortStatusN, secondPortStatusN, matchFlagOutN;
    logic [7:0] regSel;
    logic [15:0] hostWordBusOut, hostWordBusIn;
    logic [31:0] d, seenSt;
    int err_count = 0, n_tests = 0;
    // ==========================================================
    // Clock, design and device
    always #10 clk_sys = ~clk_sys;
    cam_host_ctrl dut_u (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .portSelN(portSelN), .rwN(rwN),
        .regSel(regSel), .hostWordBusOut(hostWordBusOut),
        .hostWordBusOe(hostWordBusOe), .hostWordBusIn(hostWordBusIn),
        .hardResetN(hardResetN),
        .sequencePointerClearN(sequencePointerClearN),
        .searchKeyBus(searchKeyBus), .keyStrobe(keyStrobe),
        .resultRdN(resultRdN), .resultOeN(resultOeN), .resultBus(resultBus),
        .firstPortStatusN(firstPortStatusN),
        .secondPortStatusN(secondPortStatusN),
        .matchFlagOutN(matchFlagOutN), .portCountStrap(portCountStrap),
        .upstreamMatchInN(upstreamMatchInN));
    // Flag chain fed from the head of chain
    cam_dev_model dev_u (.portSelN(portSelN), .rwN(rwN), .regSel(regSel),
        .hostWordBusOut(hostWordBusOut), .hostWordBusOe(hostWordBusOe),
        .hostWordBusIn(hostWordBusIn), .hardResetN(hardResetN),
        .sequencePointerClearN(sequencePointerClearN),
        .searchKeyBus(searchKeyBus), .keyStrobe(keyStrobe), .posPol(posPol),
        .resultRdN(resultRdN), .resultOeN(resultOeN), .resultBus(resultBus),
        .portCountStrap(portCountStrap), .upstreamMatchInN(upstreamMatchInN),
        .firstPortStatusN(firstPortStatusN),
        .secondPortStatusN(secondPortStatusN),
        .matchFlagOutN(matchFlagOutN));
    // ==========================================================
    // Bus tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 v = regRdData;
    endtask
    task automatic check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Issue one operation, poll busy with a bound, collect status seen
    task automatic op(input logic [2:0] code, input logic [7:0] sel);
        logic [31:0] s;
        seenSt = 32'h0;
        wr(`CAM_OFF_CMD, {16'h0, sel, 5'h0, code});
        s = 32'h1;
        for (int i = 0; i < 40 && s[`CAM_ST_BUSY] !== 1'b0; i++) begin
            rd(`CAM_OFF_STATUS, s);
            seenSt = seenSt | s;
        end
        check("busy", {31'h0, s[`CAM_ST_BUSY]}, 32'h0);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Hang guard well beyond the expected run
    initial begin
        #300000;
        err_count++;
        end_sim();
    end
    // ==========================================================
    // Tests
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        rd(`CAM_OFF_CTRL, d);
        check("ctrl reset", d, {28'h0, `CAM_CTRL_RST});
        rd(8'hFC, d);
        check("unmapped", d, 32'h0);
        $display("test reset done");
        // Host write then read back, two registers
        for (int k = 0; k < 2; k++) begin
            wr(`CAM_OFF_WDATA, 32'h0000A55A ^ k);
            op(cam_pkg::OP_HOST_WR, 8'(3 + k));
            check("host st", {30'h0, seenSt[2:1]}, 32'h3);
        end
        for (int k = 1; k >= 0; k--) begin
            op(cam_pkg::OP_HOST_RD, 8'(3 + k));
            rd(`CAM_OFF_RDATA, d);
            check("host word", d & 32'hFFFF, 32'h0000A55A ^ k);
        end
        $display("test host done");
        // Key width and polarity table, hit flag per key
        wr(`CAM_OFF_WDATA, 32'h89ABCDEF);
        for (int k = 0; k < 3; k++) begin
            posPol = (k == 2);
            wr(`CAM_OFF_CTRL, k == 0 ? 32'h0 : k == 1 ? 32'h2 : 32'hC);
            op(cam_pkg::OP_KEY, 8'h00);
            check("key st", {30'h0, seenSt[2:1]}, 32'h2);
            check("key", dev_u.keyQ, k == 0 ? 32'h89ABCDEF :
                k == 1 ? 32'h000000EF : 32'h0000CDEF);
            rd(`CAM_OFF_STATUS, d);
            check("match", {31'h0, d[`CAM_ST_MATCH]}, k == 2);
        end
        $display("test key done");
        // Pointer clear then two result reads, then clear and one read
        for (int k = 0; k < 2; k++) begin
            op(cam_pkg::OP_SEQ_CLR, 8'h00);
            for (int j = 0; j < 2 - k; j++) begin
                op(cam_pkg::OP_RESULT, 8'h00);
                check("result st", {30'h0, seenSt[2:1]}, 32'h1);
                rd(`CAM_OFF_RDATA, d);
                check("result", d, 32'hC0DE0000 | j);
            end
        end
        $display("test result done");
        // Strap high, hard reset wipes the device
        wr(`CAM_OFF_CTRL, 32'hD);
        // Strap register lands at the write edge; look once it settled
        @(negedge clk_sys);
        check("strap", {31'h0, portCountStrap}, 32'h1);
        op(cam_pkg::OP_HARD_RST, 8'h00);
        op(cam_pkg::OP_HOST_RD, 8'h03);
        check("strap host st", {30'h0, seenSt[2:1]}, 32'h0);
        rd(`CAM_OFF_RDATA, d);
        check("after reset", d & 32'hFFFF, 32'h0);
        rd(`CAM_OFF_STATUS, d);
        check("match cleared", {31'h0, d[`CAM_ST_MATCH]}, 32'h0);
        op(cam_pkg::OP_RESULT, 8'h00);
        check("strap rd st", {30'h0, seenSt[2:1]}, 32'h1);
        op(cam_pkg::OP_KEY, 8'h00);
        check("strap key st", {30'h0, seenSt[2:1]}, 32'h2);
        $display("test hard reset done");
        end_sim();
    end
endmodule
